//--- src/byte_sum.sv
// running 8-bit modulo sum for check bytes
// assumes clear and add come from the same clock domain
`timescale 1ns/1ps
module byte_sum (
    // clock and reset
    input  wire logic       clock,
    input  wire logic       rst_n,
    // control
    input  wire logic       clr,
    input  wire logic       add,
    input  wire logic [7:0] din,
    // result
    output logic      [7:0] sum_r
);
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            sum_r <= 8'h00;
        end else if (clr) begin
            sum_r <= 8'h00;
        end else if (add) begin
            sum_r <= sum_r + din;
        end
    end
endmodule : byte_sum

//--- src/irq_if.sv
// interrupt status and mask traffic between core and interrupt unit
// assumes one clock domain
`timescale 1ns/1ps
interface irq_if;
    pm_pkg::irq_bits_t set_ev;
    logic              wr_clr;
    logic              wr_mask;
    pm_pkg::irq_bits_t wdata;
    pm_pkg::irq_bits_t status;
    pm_pkg::irq_bits_t mask;
    modport core (output set_ev, output wr_clr, output wr_mask, output wdata,
                  input status, input mask);
    modport unit (input set_ev, input wr_clr, input wr_mask, input wdata,
                  output status, output mask);
endinterface : irq_if

//--- src/irq_unit.sv
// sticky event status, write-one-to-clear, mask, one level interrupt
// assumes events are one-cycle pulses on the same clock
`timescale 1ns/1ps
module irq_unit (
    // clock and reset
    input  wire logic clock,
    input  wire logic rst_n,
    // core side
    irq_if.unit       bus,
    // interrupt
    output logic      irq
);
    pm_pkg::irq_bits_t status_r;
    pm_pkg::irq_bits_t mask_r;

    // a new event beats a clear in the same cycle
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            status_r <= 2'h0;
        end else begin
            status_r <= (status_r & ~(bus.wr_clr ? bus.wdata : 2'h0)) | bus.set_ev;
        end
    end

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            mask_r <= 2'h0;
        end else if (bus.wr_mask) begin
            mask_r <= bus.wdata;
        end
    end

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            irq <= 1'b0;
        end else begin
            irq <= |(status_r & mask_r);
        end
    end

    assign bus.status = status_r;
    assign bus.mask   = mask_r;
endmodule : irq_unit

//--- src/pm_data_command_reply.sv
// performance-monitoring data command: command page, checks, record fetch, reply
// assumes a same-clock pm statistics source with request/valid handshake
//
// Summary of operation
// (R1) lane mask bytes 140-143, bit i is lane i+1; only set lanes are reported
// (R2) metric byte 144: bit0 snr, bit1 ltp, bit2 pre-fec ber; bits 3-7 zero
// (R3) bytes 145-147 reserved, 148-151 restricted, 152-155 custom; no meaning given
// (R4) completion flag in status byte 8 set when processing has finished
// (R5) in progress status 10xxxxxx: captured, checking, executing
// (R6) success status is 00000001
// (R7) failure 01xxxxxx: 000000 unspecified, 000010 parameter, 000101 check byte
// (R8) reply length in byte 134, reply check byte in byte 135
// (R9) reply records in bytes 136-255, 6 or 8 bytes per metric
// (R10) byte 136 bit 0 picks 6-byte or 8-byte records with current value
// (R11) host reads reply only after completion flag and success code
//
// Design decision made here: the plain strobed port.
`timescale 1ns/1ps
`include "pm_params.svh"
module pm_data_command_reply #(
    parameter int DATA_BYTES = `DATA_BYTES
) (
    // clock and reset
    input  wire logic        clock,
    input  wire logic        rst_n,
    // register port
    input  wire logic [7:0]  addr,
    input  wire logic [7:0]  wdata,
    input  wire logic        wr_en,
    input  wire logic        rd_en,
    output logic      [7:0]  rdata,
    // pm statistics source
    output logic             pm_req,
    output logic      [4:0]  pm_lane,
    output logic      [1:0]  pm_metric,
    input  wire logic        pm_valid,
    input  wire logic        pm_error,
    input  wire logic [15:0] pm_min,
    input  wire logic [15:0] pm_mean,
    input  wire logic [15:0] pm_max,
    input  wire logic [15:0] pm_cur,
    // interrupt
    output logic             irq
);
    pm_pkg::state_t state_r;
    logic        rec_size_r;
    logic [31:0] lanes_r;
    logic [7:0]  metric_r;
    logic [7:0]  cmd_chk_r;
    logic [7:0]  rpl_len_r;
    logic [7:0]  rpl_chk_r;
    logic        done_r;
    logic [7:0]  status_r;
    logic        w_size;
    logic [31:0] w_lanes;
    logic [7:0]  w_metric;
    logic [7:0]  w_chk;
    logic [3:0]  idx_r;
    logic [4:0]  lane_r;
    logic [1:0]  met_r;
    logic [2:0]  byte_r;
    logic [6:0]  wptr_r;
    logic [63:0] val_r;
    logic [7:0]  buf_r [DATA_BYTES];
    logic        pm_req_r;
    logic [1:0]  ev_r;
    logic [7:0]  rdata_r;
    logic [7:0]  csum;
    logic [7:0]  rsum;
    logic [7:0]  chk_byte;
    logic [7:0]  rec_byte;
    logic [9:0]  total;
    logic        start;
    logic        last_pos;
    logic        sel_now;
    logic        show_reply;

    irq_if ib ();

    ////////////////////////////////////////////////////////////////////////
    // helpers

    function automatic logic [5:0] popcount(input logic [31:0] v);
        logic [5:0] n;
        n = 6'h00;
        for (int i = 0; i < 32; i++) begin
            n = n + {5'h00, v[i]};
        end
        return n;
    endfunction : popcount

    assign start    = wr_en && addr == `OFS_START && state_r == pm_pkg::S_IDLE;
    assign last_pos = lane_r == 5'h1f && met_r == 2'h2;
    assign sel_now  = w_lanes[lane_r] && w_metric[met_r]; // R1 R2
    // lanes carried big-endian, byte 143 holds lanes 1 to 8
    always_comb begin
        case (idx_r)
            4'h0:    chk_byte = {7'h00, w_size};
            4'h4:    chk_byte = w_lanes[31:24];
            4'h5:    chk_byte = w_lanes[23:16];
            4'h6:    chk_byte = w_lanes[15:8];
            4'h7:    chk_byte = w_lanes[7:0];
            4'h8:    chk_byte = w_metric;
            default: chk_byte = 8'h00;
        endcase
    end
    // record: min, mean, max, then current; each 16-bit value msb first
    always_comb begin
        case (byte_r)
            3'h0:    rec_byte = val_r[63:56];
            3'h1:    rec_byte = val_r[55:48];
            3'h2:    rec_byte = val_r[47:40];
            3'h3:    rec_byte = val_r[39:32];
            3'h4:    rec_byte = val_r[31:24];
            3'h5:    rec_byte = val_r[23:16];
            3'h6:    rec_byte = val_r[15:8];
            default: rec_byte = val_r[7:0];
        endcase
    end
    // R9 R10
    assign total = 10'(popcount(w_lanes) * popcount({29'h0, w_metric[2:0]}) * (w_size ? 4'h8 : 4'h6));

    byte_sum u_cmd_sum (
        .clock (clock),
        .rst_n (rst_n),
        .clr   (state_r == pm_pkg::S_CAPT),
        .add   (state_r == pm_pkg::S_CHECK && idx_r < `CHK_COUNT),
        .din   (chk_byte),
        .sum_r (csum)
    );

    byte_sum u_rpl_sum (
        .clock (clock),
        .rst_n (rst_n),
        .clr   (state_r == pm_pkg::S_CAPT),
        .add   (state_r == pm_pkg::S_STORE),
        .din   (rec_byte),
        .sum_r (rsum)
    );

    irq_unit u_irq (
        .clock (clock),
        .rst_n (rst_n),
        .bus   (ib.unit),
        .irq   (irq)
    );

    assign ib.set_ev  = ev_r;
    assign ib.wr_clr  = wr_en && addr == `OFS_INT_STAT;
    assign ib.wr_mask = wr_en && addr == `OFS_INT_MASK;
    assign ib.wdata   = wdata[1:0];

    ////////////////////////////////////////////////////////////////////////
    // command fields written by the host; reserved bytes are dropped

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            rec_size_r <= 1'b0;
            lanes_r    <= 32'h0;
            metric_r   <= 8'h00;
            cmd_chk_r  <= 8'h00;
        end else if (wr_en) begin
            case (addr)
                `OFS_REC_SIZE:  rec_size_r     <= wdata[0]; // R10
                `OFS_LANES:     lanes_r[31:24] <= wdata; // R1
                8'h8d:          lanes_r[23:16] <= wdata;
                8'h8e:          lanes_r[15:8]  <= wdata;
                8'h8f:          lanes_r[7:0]   <= wdata;
                `OFS_METRIC:    metric_r       <= wdata; // R2
                `OFS_CMD_CHK:   cmd_chk_r      <= wdata;
                default: begin
                end
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // sequencer

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            state_r  <= pm_pkg::S_IDLE;
            status_r <= `ST_IDLE;
            done_r   <= 1'b0;
            ev_r     <= 2'h0;
            idx_r    <= 4'h0;
            lane_r   <= 5'h00;
            met_r    <= 2'h0;
            byte_r   <= 3'h0;
            wptr_r   <= 7'h00;
            pm_req_r <= 1'b0;
            val_r    <= 64'h0;
            w_size   <= 1'b0;
            w_lanes  <= 32'h0;
            w_metric <= 8'h00;
            w_chk    <= 8'h00;
        end else begin
            ev_r <= 2'h0;
            case (state_r)
                pm_pkg::S_IDLE: begin
                    if (start) begin
                        // the command is frozen so later host writes cannot disturb it
                        w_size   <= rec_size_r;
                        w_lanes  <= lanes_r;
                        w_metric <= metric_r;
                        w_chk    <= cmd_chk_r;
                        done_r   <= 1'b0;
                        status_r <= `ST_CAPTURED; // R5
                        state_r  <= pm_pkg::S_CAPT;
                    end
                end
                pm_pkg::S_CAPT: begin
                    idx_r    <= 4'h0;
                    status_r <= `ST_CHECKING; // R5
                    state_r  <= pm_pkg::S_CHECK;
                end
                pm_pkg::S_CHECK: begin
                    if (idx_r != `CHK_COUNT) begin
                        idx_r <= idx_r + 4'h1;
                    end else if (8'(csum + w_chk) != 8'hff) begin
                        status_r <= `ST_FAIL_CHK; // R7
                        done_r   <= 1'b1; // R4
                        ev_r     <= 2'h2;
                        state_r  <= pm_pkg::S_IDLE;
                    end else if ((w_metric & `METRIC_RSVD) != 8'h00 || total == 10'h0
                                 || total > 10'(DATA_BYTES)) begin
                        status_r <= `ST_FAIL_PARAM; // R2 R7 R9
                        done_r   <= 1'b1; // R4
                        ev_r     <= 2'h2;
                        state_r  <= pm_pkg::S_IDLE;
                    end else begin
                        lane_r   <= 5'h00;
                        met_r    <= 2'h0;
                        wptr_r   <= 7'h00;
                        status_r <= `ST_EXECUTING; // R5
                        state_r  <= pm_pkg::S_EXEC;
                    end
                end
                pm_pkg::S_EXEC: begin
                    if (sel_now) begin
                        pm_req_r <= 1'b1; // R1 R2
                        state_r  <= pm_pkg::S_WAIT;
                    end else if (last_pos) begin
                        state_r <= pm_pkg::S_FIN;
                    end else begin
                        met_r  <= met_r == 2'h2 ? 2'h0 : met_r + 2'h1;
                        lane_r <= met_r == 2'h2 ? lane_r + 5'h01 : lane_r;
                    end
                end
                pm_pkg::S_WAIT: begin
                    if (pm_valid) begin
                        pm_req_r <= 1'b0;
                        if (pm_error) begin
                            status_r <= `ST_FAIL_ANY; // R7
                            done_r   <= 1'b1; // R4
                            ev_r     <= 2'h2;
                            state_r  <= pm_pkg::S_IDLE;
                        end else begin
                            val_r   <= {pm_min, pm_mean, pm_max, pm_cur};
                            byte_r  <= 3'h0;
                            state_r <= pm_pkg::S_STORE;
                        end
                    end
                end
                pm_pkg::S_STORE: begin
                    wptr_r <= wptr_r + 7'h01;
                    byte_r <= byte_r + 3'h1;
                    if (byte_r == (w_size ? 3'h7 : 3'h5)) begin // R10
                        if (last_pos) begin
                            state_r <= pm_pkg::S_FIN;
                        end else begin
                            met_r   <= met_r == 2'h2 ? 2'h0 : met_r + 2'h1;
                            lane_r  <= met_r == 2'h2 ? lane_r + 5'h01 : lane_r;
                            state_r <= pm_pkg::S_EXEC;
                        end
                    end
                end
                pm_pkg::S_FIN: begin
                    status_r <= `ST_SUCCESS; // R6
                    done_r   <= 1'b1; // R4
                    ev_r     <= 2'h1;
                    state_r  <= pm_pkg::S_IDLE;
                end
                default: state_r <= pm_pkg::S_IDLE;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // reply storage and header

    always_ff @(posedge clock) begin
        if (state_r == pm_pkg::S_STORE) begin
            buf_r[wptr_r] <= rec_byte; // R9
        end
    end

    // host may write the header bytes; a successful finish (S_FIN) overwrites them, a failed completion leaves them
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            rpl_len_r <= 8'h00;
            rpl_chk_r <= 8'h00;
        end else if (state_r == pm_pkg::S_FIN) begin
            rpl_len_r <= {1'b0, wptr_r}; // R8
            rpl_chk_r <= ~rsum; // R8
        end else if (wr_en && addr == `OFS_RPL_LEN) begin
            rpl_len_r <= wdata;
        end else if (wr_en && addr == `OFS_RPL_CHK) begin
            rpl_chk_r <= wdata;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // register reads, one cycle later

    // buffer bytes are returned only below the reply length; reads past it give zero
    assign show_reply = done_r && status_r == `ST_SUCCESS && addr >= `OFS_REC_SIZE;

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            rdata_r <= 8'h00;
        end else if (rd_en) begin
            if (show_reply) begin
                rdata_r <= 8'(addr - `OFS_REC_SIZE) < rpl_len_r ? buf_r[7'(addr - `OFS_REC_SIZE)] : 8'h00;
            end else begin
                case (addr)
                    `OFS_FLAG:     rdata_r <= {done_r, 7'h00}; // R4
                    `OFS_STATUS:   rdata_r <= status_r;
                    `OFS_INT_STAT: rdata_r <= {6'h00, ib.status};
                    `OFS_INT_MASK: rdata_r <= {6'h00, ib.mask};
                    `OFS_CMD_CHK:  rdata_r <= cmd_chk_r;
                    `OFS_RPL_LEN:  rdata_r <= rpl_len_r;
                    `OFS_RPL_CHK:  rdata_r <= rpl_chk_r;
                    `OFS_REC_SIZE: rdata_r <= {7'h00, rec_size_r};
                    `OFS_LANES:    rdata_r <= lanes_r[31:24];
                    8'h8d:         rdata_r <= lanes_r[23:16];
                    8'h8e:         rdata_r <= lanes_r[15:8];
                    8'h8f:         rdata_r <= lanes_r[7:0];
                    `OFS_METRIC:   rdata_r <= metric_r;
                    default:       rdata_r <= 8'h00; // R3
                endcase
            end
        end
    end

    assign rdata     = rdata_r;
    assign pm_req    = pm_req_r;
    assign pm_lane   = lane_r;
    assign pm_metric = met_r;

    ////////////////////////////////////////////////////////////////////////
    // checks

    default clocking cb @(posedge clock); endclocking
    default disable iff (!rst_n);

    property p_busy_code;
        state_r inside {pm_pkg::S_CAPT, pm_pkg::S_CHECK, pm_pkg::S_EXEC, pm_pkg::S_WAIT}
            |-> status_r[7:6] == 2'b10 && !done_r;
    endproperty
    a_busy_code: assert property (p_busy_code) else $error("busy without in-progress code"); // R5

    property p_start_seq;
        start |=> status_r == `ST_CAPTURED ##1 status_r == `ST_CHECKING;
    endproperty
    a_start_seq: assert property (p_start_seq) else $error("start did not walk captured then checking"); // R5

    property p_done_code;
        $rose(done_r) |-> status_r[7:6] != 2'b10 && state_r == pm_pkg::S_IDLE;
    endproperty
    a_done_code: assert property (p_done_code) else $error("completion flag with busy code"); // R4

    logic irq_ok_seen;
    assign irq_ok_seen = ev_r[`INT_OK];
    property p_success;
        state_r == pm_pkg::S_FIN |=> done_r && status_r == `ST_SUCCESS && irq_ok_seen;
    endproperty
    a_success: assert property (p_success) else $error("success not reported after finish"); // R6

    property p_rsvd_metric;
        state_r == pm_pkg::S_CHECK && idx_r == `CHK_COUNT && 8'(csum + w_chk) == 8'hff
            && (w_metric & `METRIC_RSVD) != 8'h00 |=> status_r == `ST_FAIL_PARAM;
    endproperty
    a_rsvd_metric: assert property (p_rsvd_metric) else $error("reserved metric bits accepted"); // R7

    property p_req_sel;
        pm_req_r |-> w_lanes[pm_lane] && w_metric[pm_metric];
    endproperty
    a_req_sel: assert property (p_req_sel) else $error("request for unselected lane or metric"); // R1

    property p_rec_len;
        $rose(done_r) && status_r == `ST_SUCCESS
            |-> rpl_len_r == 8'(total) && rpl_chk_r == ~rsum && rpl_len_r <= 8'(DATA_BYTES);
    endproperty
    a_rec_len: assert property (p_rec_len) else $error("reply length or check byte wrong"); // R8

    property p_rec_size;
        state_r == pm_pkg::S_STORE |-> byte_r <= (w_size ? 3'h7 : 3'h5);
    endproperty
    a_rec_size: assert property (p_rec_size) else $error("record longer than selected size"); // R10

    property p_rsvd_read;
        rd_en && !show_reply && addr >= `OFS_RSVD_LO && addr <= `OFS_RSVD_HI |=> rdata == 8'h00;
    endproperty
    a_rsvd_read: assert property (p_rsvd_read) else $error("reserved byte read non-zero"); // R3

    c_success:  cover property (state_r == pm_pkg::S_FIN ##1 done_r);
    c_chk_fail: cover property ($rose(done_r) && status_r == `ST_FAIL_CHK);
    c_long_rec: cover property (state_r == pm_pkg::S_STORE && byte_r == 3'h7);
endmodule : pm_data_command_reply

//--- src/pm_params.svh
// offsets, field positions, status codes and counts of the pm command block
// assumes an 8-bit page address and byte-wide register port
`ifndef PM_PARAMS_SVH
`define PM_PARAMS_SVH
`define OFS_FLAG      8'h08
`define FLAG_BIT      7
`define OFS_STATUS    8'h25
`define OFS_START     8'h80
`define OFS_INT_STAT  8'h81
`define OFS_INT_MASK  8'h82
`define OFS_CMD_CHK   8'h85
`define OFS_RPL_LEN   8'h86
`define OFS_RPL_CHK   8'h87
`define OFS_REC_SIZE  8'h88
`define OFS_LANES     8'h8c
`define OFS_METRIC    8'h90
`define OFS_RSVD_LO   8'h91
`define OFS_RSVD_HI   8'h9b
`define DATA_BYTES    120
`define CHK_COUNT     4'h9
`define METRIC_RSVD   8'hf8
`define ST_IDLE       8'h00
`define ST_CAPTURED   8'h81
`define ST_CHECKING   8'h82
`define ST_EXECUTING  8'h83
`define ST_SUCCESS    8'h01
`define ST_FAIL_ANY   8'h40
`define ST_FAIL_PARAM 8'h42
`define ST_FAIL_CHK   8'h45
`define INT_OK        0
`define INT_FAIL      1
`endif

//--- src/pm_pkg.sv
// types shared by the pm command block
// assumes pm_params.svh carries every number
package pm_pkg;
    typedef enum logic [2:0] {
        S_IDLE,
        S_CAPT,
        S_CHECK,
        S_EXEC,
        S_WAIT,
        S_STORE,
        S_FIN
    } state_t;
    typedef logic [1:0] irq_bits_t;
endpackage : pm_pkg

//--- test/pm_source_model.sv
// pm statistics source model: answers each request after a set delay
// assumes requests hold until answered, same clock as the block
`timescale 1ns/1ps
module pm_source_model (
    // clock and reset
    input  wire logic        clock,
    input  wire logic        rst_n,
    // block side
    input  wire logic        pm_req,
    input  wire logic [4:0]  pm_lane,
    input  wire logic [1:0]  pm_metric,
    output logic             pm_valid,
    output logic             pm_error,
    output logic      [15:0] pm_min,
    output logic      [15:0] pm_mean,
    output logic      [15:0] pm_max,
    output logic      [15:0] pm_cur,
    // bench control
    input  wire logic [3:0]  dly,
    input  wire logic        fail
);
    logic [3:0]  cnt_r;
    logic [15:0] inv;
    ////////////////////////////////////////
    // off-answer values are inverted so stale data never looks right
    assign inv      = {16{~pm_valid}};
    assign pm_min   = {3'h0, pm_lane, 2'h0, pm_metric, 4'h1} ^ inv;
    assign pm_mean  = {3'h0, pm_lane, 2'h0, pm_metric, 4'h2} ^ inv;
    assign pm_max   = {3'h0, pm_lane, 2'h0, pm_metric, 4'h3} ^ inv;
    assign pm_cur   = {3'h0, pm_lane, 2'h0, pm_metric, 4'h4} ^ inv;
    assign pm_error = pm_valid & fail;
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            cnt_r    <= 4'h0;
            pm_valid <= 1'b0;
        end else begin
            pm_valid <= pm_req && !pm_valid && cnt_r == dly;
            cnt_r    <= (pm_req && !pm_valid) ? cnt_r + 4'h1 : 4'h0;
        end
    end
endmodule : pm_source_model

//--- test/test_pm_data_command_reply.sv
// self-checking bench for the pm command block over its register port
// assumes the pm source model answers on the same clock
`timescale 1ns/1ps
`include "pm_params.svh"
module test_pm_data_command_reply;
    logic        clock = 1'b0;
    logic        rst_n = 1'b0;
    logic [7:0]  addr = 8'h00;
    logic [7:0]  wdata = 8'h00;
    logic        wr_en = 1'b0;
    logic        rd_en = 1'b0;
    logic [7:0]  rdata, d, st;
    logic        pm_req, pm_valid, pm_error, irq;
    logic [4:0]  pm_lane;
    logic [1:0]  pm_metric;
    logic [15:0] pm_min, pm_mean, pm_max, pm_cur;
    logic [3:0]  dly = 4'h9;
    logic [3:0]  seen;
    logic        fail = 1'b0;
    int          error_cnt = 0;
    int          compares = 0;
    logic [7:0]  q[$];
    logic [31:0] fm[6] = '{32'h1, 32'h1, 32'h0, 32'h1, 32'hffffffff, 32'h1};
    logic [7:0]  fo[6] = '{8'h01, 8'h09, 8'h01, 8'h00, 8'h07, 8'h01};
    logic [7:0]  fc[6] = '{`ST_FAIL_CHK, `ST_FAIL_PARAM, `ST_FAIL_PARAM, `ST_FAIL_PARAM, `ST_FAIL_PARAM, `ST_FAIL_ANY};
    always #50 clock = ~clock;
    pm_data_command_reply i_dut (.clock, .rst_n, .addr, .wdata, .wr_en, .rd_en, .rdata, .pm_req, .pm_lane,
        .pm_metric, .pm_valid, .pm_error, .pm_min, .pm_mean, .pm_max, .pm_cur, .irq);
    pm_source_model i_src (.clock, .rst_n, .pm_req, .pm_lane, .pm_metric, .pm_valid, .pm_error, .pm_min,
        .pm_mean, .pm_max, .pm_cur, .dly, .fail);
    ////////////////////////////////////////
    task chk(input string n, input logic [7:0] e, input logic [7:0] g);
        compares++;
        if (g !== e) begin
            error_cnt++;
            $display("MISMATCH %s expected %h seen %h", n, e, g);
        end
    endtask : chk
    task wr(input logic [7:0] a, input logic [7:0] v);
        @(posedge clock);
        addr  <= a;
        wdata <= v;
        wr_en <= 1'b1;
        @(posedge clock);
        wr_en <= 1'b0;
    endtask : wr
    task rd(input logic [7:0] a);
        @(posedge clock);
        addr  <= a;
        rd_en <= 1'b1;
        @(posedge clock);
        rd_en <= 1'b0;
        @(negedge clock);
        d = rdata;
    endtask : rd
    task rc(input string n, input logic [7:0] a, input logic [7:0] e);
        rd(a);
        chk(n, e, d);
    endtask : rc
    // irq is registered from the status bits, so it lags a set or clear by a cycle
    task ci(input logic e);
        @(posedge clock);
        @(negedge clock);
        chk("irq", {7'h0, e}, {7'h0, irq});
    endtask : ci
    // fix flips check bits to force a bad command check byte
    task run(input logic [31:0] m, input logic [7:0] o, input logic r, input logic [7:0] fix);
        logic [7:0] s;
        s = ~({7'h0, r} + m[31:24] + m[23:16] + m[15:8] + m[7:0] + o) ^ fix;
        seen = 4'h0;
        wr(`OFS_REC_SIZE, {7'h0, r});
        for (int i = 0; i < 4; i++) wr(8'(`OFS_LANES + i), m[31 - 8 * i -: 8]);
        wr(`OFS_METRIC, o);
        wr(`OFS_CMD_CHK, s);
        wr(`OFS_START, 8'h00);
        for (int n = 0; n < 300; n++) begin
            rd(`OFS_STATUS);
            if (!d[7]) break;
            chk("busy code", {6'h20, d[1:0]}, d);
            seen[d[1:0]] = 1'b1;
        end
        st = d;
        rc("status holds", `OFS_STATUS, st);
        rc("flag", `OFS_FLAG, 8'h80);
    endtask : run
    task rep(input logic [31:0] m, input logic [7:0] o, input logic r);
        logic [15:0] v;
        logic [7:0]  s;
        q = {};
        s = 8'h00;
        for (int l = 0; l < 32; l++)
            for (int k = 0; k < 3; k++)
                for (int j = 1; j <= (r ? 4 : 3); j++)
                    if (m[l] && o[k]) begin
                        v = {3'h0, 5'(l), 2'h0, 2'(k), 4'(j)};
                        q.push_back(v[15:8]);
                        q.push_back(v[7:0]);
                    end
        rc("length", `OFS_RPL_LEN, 8'(q.size()));
        foreach (q[i]) rc("reply data", 8'(`OFS_REC_SIZE + i), q[i]);
        foreach (q[i]) s += q[i];
        rc("reply check", `OFS_RPL_CHK, ~s);
        rc("past length", 8'(`OFS_REC_SIZE + q.size()), 8'h00);
    endtask : rep
    task final_report;
        if (error_cnt == 0 && compares > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask : final_report
    ////////////////////////////////////////
    initial begin
        repeat (20000) @(posedge clock);
        error_cnt++;
        final_report;
    end
    initial begin
        repeat (16) @(posedge clock);
        rst_n <= 1'b1;
        rc("status", `OFS_STATUS, `ST_IDLE);
        rc("flag", `OFS_FLAG, 8'h00);
        ci(1'b0);
        wr(`OFS_INT_MASK, 8'h03);
        wr(8'h91, 8'haa);
        rc("reserved", 8'h91, 8'h00);
        run(32'h0000_0005, 8'h05, 1'b0, 8'h00);
        chk("status", `ST_SUCCESS, st);
        chk("phases", 8'h0c, {4'h0, seen & 4'hc});
        rep(32'h0000_0005, 8'h05, 1'b0);
        rc("int status", `OFS_INT_STAT, 8'h01);
        ci(1'b1);
        wr(`OFS_INT_STAT, 8'h01);
        ci(1'b0);
        dly <= 4'h0;
        run(32'h8000_0000, 8'h02, 1'b1, 8'h00);
        chk("status", `ST_SUCCESS, st);
        rep(32'h8000_0000, 8'h02, 1'b1);
        wr(`OFS_INT_STAT, 8'h01);
        wr(`OFS_INT_MASK, 8'h01);
        for (int i = 0; i < 6; i++) begin
            fail <= (i == 5);
            run(fm[i], fo[i], i == 4, {7'h0, i == 0});
            chk("fail status", fc[i], st);
            rc("int status", `OFS_INT_STAT, 8'h02);
            ci(1'b0);
            if (i < 5) wr(`OFS_INT_STAT, 8'h02);
        end
        wr(`OFS_INT_MASK, 8'h03);
        ci(1'b1);
        wr(`OFS_INT_STAT, 8'h02);
        rc("int status", `OFS_INT_STAT, 8'h00);
        ci(1'b0);
        final_report;
    end
endmodule : test_pm_data_command_reply
